/* hdl/burst_sram_pkg.sv */
// Constants shared by the pipelined burst SRAM access block
`default_nettype none
package burst_sram_pkg;
  // Default address width (word address)
  localparam int ADDR_W_DEF = 10;
  // Default number of byte lanes
  localparam int LANES_DEF = 4;
  // Data bits per lane, parity excluded
  localparam int LANE_BITS_DEF = 8;
  // Burst counter width; four beats
  localparam int BURST_W = 2;
  // Depth of the read-data FIFO
  localparam int FIFO_DEPTH_DEF = 8;
  // Burst step values
  localparam logic [1:0] BURST_ZERO = 2'h0;
  localparam logic [1:0] BURST_ONE = 2'h1;
  // Burst order strap values
  localparam logic ORDER_LINEAR = 1'b0;
  localparam logic ORDER_INTERLEAVED = 1'b1;
endpackage : burst_sram_pkg
`default_nettype wire

/* hdl/pipelined_burst_sram_access.sv */
// Pipelined burst SRAM access logic with a read-data FIFO
`default_nettype none
module rd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Storage array
  logic [WIDTH-1:0] mem [DEPTH];
  // Pointers and fill count
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;
  // Full compare at the count's own width; a pointer-wide cast of DEPTH wraps to zero
  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem[rp_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Pointer and count update
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wp_ff <= (wp_ff == AW'(DEPTH - 1)) ? '0 : wp_ff + AW'(1);
      end
      if (pop) begin
        rp_ff <= (rp_ff == AW'(DEPTH - 1)) ? '0 : rp_ff + AW'(1);
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Array write, no reset needed on data
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp_ff] <= in_data;
    end
  end
endmodule : rd_fifo

module pipelined_burst_sram_access
  import burst_sram_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LANES = LANES_DEF,
  parameter int LANE_BITS = LANE_BITS_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Synchronous control inputs
  input wire logic clk_qualify_n,
  input wire logic chip_sel_a_n,
  input wire logic chip_sel_b,
  input wire logic chip_sel_c_n,
  input wire logic write_sel_n,
  input wire logic advance_load_n,
  input wire logic [LANES-1:0] byte_lane_wr_n,
  input wire logic [ADDR_W-1:0] addr,
  // Asynchronous inputs
  input wire logic out_en_n,
  input wire logic sleep_req,
  // Burst order strap
  input wire logic burst_order,
  // Data bus, split into three signals
  input wire logic [LANES*LANE_BITS-1:0] data_in,
  output logic [LANES*LANE_BITS-1:0] data_out,
  output logic data_oe,
  input wire logic [LANES-1:0] parity_in,
  output logic [LANES-1:0] parity_out,
  output logic parity_oe,
  // Status
  output logic sleeping,
  // Read-data stream taken from the FIFO
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [LANES*(LANE_BITS+1)-1:0] rd_data
);
  localparam int DW = LANES * LANE_BITS;
  localparam int WW = LANES * (LANE_BITS + 1);
  localparam int DEPTH = 1 << ADDR_W;

  // Memory array, data and parity per lane
  logic [WW-1:0] array_mem [DEPTH];

  // Whole registered state
  typedef struct packed {
    logic [ADDR_W-1:0] base;     // Loaded start address
    logic [BURST_W-1:0] beat;    // Burst count
    logic active;                // Selected access in burst
    logic is_wr;                 // Access type kept for burst
    logic rd_p1;                 // Read data due next clock
    logic wr_p1;                 // Write data due next clock
    logic [ADDR_W-1:0] wa_p1;    // Address for pending read or write
    logic wr_p2;                 // Write data phase now
    logic [ADDR_W-1:0] wa_p2;
    logic [LANES-1:0] be_p2;     // Byte selects for write phase
    logic first_after_desel;     // Mask drive one clock
    logic drive;                 // Output drivers on
    logic oe_q;                  // Pin enable, drive gated by synced enable
    logic [WW-1:0] q;            // Output register
    logic push;                  // Read beat into FIFO
    logic [1:0] sleep_s;         // Sleep synchroniser
    logic oe_s1;                 // Output enable synchroniser
    logic oe_s2;
    logic order;                 // Strap caught after reset
    logic strap_done;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  // Burst address bits for either order
  function automatic logic [1:0] burst_bits(input logic [1:0] start, input logic [1:0] cnt,
                                            input logic ord);
    burst_bits = (ord == ORDER_INTERLEAVED) ? (start ^ cnt) : 2'(start + cnt);
  endfunction : burst_bits

  // Lane interleave of data and parity into one word
  function automatic logic [WW-1:0] pack_word(input logic [DW-1:0] d, input logic [LANES-1:0] p);
    for (int i = 0; i < LANES; i++) begin
      pack_word[i*(LANE_BITS+1) +: (LANE_BITS+1)] = {p[i], d[i*LANE_BITS +: LANE_BITS]};
    end
  endfunction : pack_word

  logic selected;
  logic load;
  logic adv;
  logic [ADDR_W-1:0] cur_addr;
  logic fifo_ready;
  logic frozen;

  assign frozen = clk_qualify_n || st_ff.sleep_s[1];
  assign selected = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
  assign load = !advance_load_n;
  assign adv = advance_load_n && st_ff.active;

  // Next state
  always_comb begin
    logic [1:0] nb;
    logic [ADDR_W-1:0] a;
    nb = '0;
    a = '0;
    nxt_st = st_ff;
    nxt_st.sleep_s = {st_ff.sleep_s[0], sleep_req};
    nxt_st.oe_s1 = out_en_n;
    nxt_st.oe_s2 = st_ff.oe_s1;
    nxt_st.push = 1'b0;
    if (!st_ff.strap_done) begin
      nxt_st.order = burst_order;
      nxt_st.strap_done = 1'b1;
    end
    if (!frozen) begin
      nxt_st.rd_p1 = 1'b0;
      nxt_st.wr_p1 = 1'b0;
      nxt_st.wr_p2 = st_ff.wr_p1;
      nxt_st.wa_p2 = st_ff.wa_p1;
      nxt_st.be_p2 = ~byte_lane_wr_n;
      nxt_st.first_after_desel = 1'b0;
      if (load) begin
        // New access or deselect, taken every cycle
        nxt_st.active = selected;
        nxt_st.base = addr;
        nxt_st.beat = BURST_ZERO;
        nxt_st.is_wr = !write_sel_n;
        if (selected) begin
          nxt_st.rd_p1 = write_sel_n;
          nxt_st.wr_p1 = !write_sel_n;
          nxt_st.wa_p1 = addr;
          nxt_st.first_after_desel = !st_ff.active;
        end
      end else if (adv) begin
        nb = st_ff.beat + BURST_ONE;
        nxt_st.beat = nb;
        a = {st_ff.base[ADDR_W-1:2], burst_bits(st_ff.base[1:0], nb, st_ff.order)};
        nxt_st.rd_p1 = !st_ff.is_wr;
        nxt_st.wr_p1 = st_ff.is_wr;
        nxt_st.wa_p1 = a;
      end
      // Output register loads at the clock rise after the read was taken
      if (st_ff.rd_p1) begin
        nxt_st.q = array_mem[st_ff.wa_p1];
        // Stream mirrors the bus: a masked first beat is not streamed
        nxt_st.push = fifo_ready && !st_ff.first_after_desel;
      end
      // Drive only for read data; never in write phase
      nxt_st.drive = st_ff.rd_p1 && !st_ff.first_after_desel;
    end
    // Enable folded into a flop so the pin comes straight from a register
    nxt_st.oe_q = nxt_st.drive && !nxt_st.oe_s2;
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Self-timed write of masked lanes in the data phase
  always_ff @(posedge mclk) begin
    if (!frozen && st_ff.wr_p2) begin
      for (int i = 0; i < LANES; i++) begin
        if (st_ff.be_p2[i]) begin
          array_mem[st_ff.wa_p2][i*(LANE_BITS+1) +: (LANE_BITS+1)] <=
            {parity_in[i], data_in[i*LANE_BITS +: LANE_BITS]};
        end
      end
    end
  end

  // Output pins straight from registers; enable gated by synced OE
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      data_out[i*LANE_BITS +: LANE_BITS] = st_ff.q[i*(LANE_BITS+1) +: LANE_BITS];
      parity_out[i] = st_ff.q[i*(LANE_BITS+1) + LANE_BITS];
    end
  end
  assign data_oe = st_ff.oe_q;
  assign parity_oe = st_ff.oe_q;
  assign sleeping = st_ff.sleep_s[1];

  // Read beats also stream out through the FIFO; a beat that meets a full FIFO is dropped silently
  rd_fifo #(.WIDTH(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_valid(st_ff.push),
    .in_ready(fifo_ready),
    .in_data(st_ff.q),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // A read taken at a counted edge
  sequence read_load_s;
    !frozen && load && selected && write_sel_n;
  endsequence
  // A counted edge following
  sequence next_edge_s;
    ##1 !frozen;
  endsequence
  // Read loads made while an access is active lead to drive after the next counted edge
  read_drive_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (read_load_s and st_ff.active) ##0 next_edge_s |=> st_ff.drive)
    else $error("read data not driven");
  // Write phase never drives
  write_nodrive_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st_ff.wr_p2 |-> !data_oe)
    else $error("drive during write phase");
  // Deselect releases bus
  desel_release_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (!frozen && load && !selected) ##1 !frozen |=> !st_ff.drive)
    else $error("bus held after deselect");
  // Load takes the presented address
  load_addr_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (!frozen && load) |=> st_ff.base == $past(addr))
    else $error("address not loaded");
  // Load takes the access type from the write select
  type_load_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (!frozen && load) |=> st_ff.is_wr == !$past(write_sel_n))
    else $error("access type not loaded");
  // Advance leaves the loaded address alone
  adv_base_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (!frozen && adv) |=> $stable(st_ff.base))
    else $error("base moved on advance");
  // Sleep freezes the access state
  sleep_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st_ff.sleep_s[1] |=> $stable(st_ff.beat) && $stable(st_ff.drive))
    else $error("state moved in sleep");
  // No pin drive without a read beat
  oe_need_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !st_ff.drive |-> !data_oe && !parity_oe)
    else $error("drive without read");
  // Frozen clock holds burst count
  freeze_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    frozen |=> $stable(st_ff.beat) && $stable(st_ff.base))
    else $error("state moved while frozen");
  // Type held on advance
  type_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (!frozen && adv) |=> $stable(st_ff.is_wr))
    else $error("access type changed in burst");
  // Write reaches data phase two clocks after load
  write_phase_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (!frozen && load && selected && !write_sel_n) |=> st_ff.wr_p1 ##1 ($past(frozen) || st_ff.wr_p2))
    else $error("write phase late");
  // Fresh select masks drive
  first_mask_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_ff.first_after_desel && st_ff.rd_p1 && !frozen) |=> !st_ff.drive)
    else $error("drive right after deselect");
  // Advance steps the counter by one
  burst_step_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (!frozen && adv) |=> st_ff.beat == 2'($past(st_ff.beat) + BURST_ONE))
    else $error("burst counter wrong");
endmodule : pipelined_burst_sram_access
`default_nettype wire

/* verification/sram_bus_partner.sv */
// Controller-side partner: holds the control levels and resolves the shared data bus
`default_nettype none
module sram_bus_partner (
  // Clock
  input wire logic mclk,
  // Write data handed over by the bench
  input wire logic drv,
  input wire logic [35:0] wd,
  // Device drive side
  input wire logic [31:0] data_out,
  input wire logic [3:0] parity_out,
  input wire logic data_oe,
  input wire logic parity_oe,
  // Resolved bus and controller levels
  output logic [31:0] data_in,
  output logic [3:0] parity_in,
  output logic out_en_n,
  output logic sleep_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // Last bus level, so a released bus never repeats a stale copy
  logic [35:0] last_ff = 36'h0_0000_0000;
  always_ff @(posedge mclk) last_ff <= {parity_in, data_in};
  // Device drive wins; otherwise write data, else a pattern that flips every cycle
  always_comb begin
    data_in = data_oe ? data_out : (drv ? wd[31:0] : ~last_ff[31:0]);
    parity_in = parity_oe ? parity_out : (drv ? wd[35:32] : ~last_ff[35:32]);
  end
  assign out_en_n = 1'b0;
  assign sleep_req = 1'b0;
endmodule : sram_bus_partner
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the pipelined burst SRAM access block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus, driven by the bench
  logic mclk = 1'b0, arst_n = 1'b0, clk_qualify_n = 1'b0, qv = 1'b0;
  logic chip_sel_a_n = 1'b1, write_sel_n = 1'b1, advance_load_n = 1'b0;
  logic burst_order = 1'b0, rd_ready = 1'b0, drv = 1'b0;
  logic [3:0] byte_lane_wr_n = 4'hf, lanes = 4'h0, l1;
  logic [9:0] addr = 10'h000;
  logic [35:0] wd = 36'h0_0000_0000;
  // Design and partner outputs
  wire logic [31:0] data_in, data_out;
  wire logic [3:0] parity_in, parity_out;
  wire logic [35:0] rd_data;
  wire logic data_oe, parity_oe, sleeping, rd_valid, out_en_n, sleep_req;
  // Reference array and two-stage expectation pipeline
  logic [35:0] mem [1024];
  logic [35:0] e1, e2, d1, d2, dsave;
  logic r1, r2, m1, m2, w1, w2, prevdes, fq_on;
  logic [15:0] seq = 16'h0000;
  logic [35:0] fq [$];
  int n_errors = 0, n_compared = 0;
  pipelined_burst_sram_access pipelined_burst_sram_access_inst (
    .mclk, .arst_n, .clk_qualify_n, .chip_sel_a_n, .chip_sel_b(1'b1), .chip_sel_c_n(1'b0),
    .write_sel_n, .advance_load_n, .byte_lane_wr_n, .addr, .out_en_n, .sleep_req,
    .burst_order, .data_in, .data_out, .data_oe, .parity_in, .parity_out, .parity_oe,
    .sleeping, .rd_valid, .rd_ready, .rd_data);
  sram_bus_partner sram_bus_partner_inst (.mclk, .drv, .wd, .data_out, .parity_out,
    .data_oe, .parity_oe, .data_in, .parity_in, .out_en_n, .sleep_req);
  initial forever #12.5 mclk = ~mclk;
  // Stream packs parity above data within each lane
  function automatic logic [35:0] pk(input logic [35:0] v);
    logic [35:0] r;
    for (int i = 0; i < 4; i++) r[9*i+:9] = {v[32+i], v[8*i+:8]};
    return r;
  endfunction : pk
  task automatic chk(input string nm, input logic [35:0] ex, input logic [35:0] got);
    n_compared++;
    if (got !== ex) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic rst(input logic o);
    @(posedge mclk);
    arst_n <= 1'b0;
    burst_order <= o;
    chip_sel_a_n <= 1'b1;
    {r1, r2, w1, w2, prevdes} = 5'h01;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask : rst
  // One beat; advance beats scramble selects, write select and address pins
  task automatic step(input logic ld_n, input logic wr, input logic sel, input logic [9:0] a);
    logic [35:0] v;
    seq++;
    v = {a[3:0], a, seq, 6'h15};
    @(posedge mclk);
    clk_qualify_n <= qv;
    advance_load_n <= ld_n;
    chip_sel_a_n <= ld_n | !sel;
    write_sel_n <= ld_n ^ !wr;
    addr <= ld_n ? ~a : a;
    byte_lane_wr_n <= w1 ? l1 : 4'hf;
    drv <= w2;
    wd <= d2;
    #1;
    chk("data_oe", 36'(r2 & !m2), 36'(data_oe));
    if (r2 & !m2) chk("data_out", e2, {parity_out, data_out});
    dsave = {parity_out, data_out};
    r2 = r1;
    m2 = m1;
    e2 = e1;
    r1 = sel & !wr;
    m1 = r1 & prevdes & !ld_n;
    prevdes = !sel;
    e1 = mem[a];
    if (r1 & !m1 & fq_on & fq.size() < 8) fq.push_back(pk(e1));
    w2 = w1;
    d2 = d1;
    w1 = sel & wr;
    d1 = v;
    l1 = lanes;
    for (int i = 0; i < 4; i++)
      if (w1 & !lanes[i]) {mem[a][32+i], mem[a][8*i+:8]} = {v[32+i], v[8*i+:8]};
  endtask : step
  // Two frozen edges must leave the outputs as they were
  task automatic hold();
    qv = 1'b0;
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      if (i == 1) clk_qualify_n <= 1'b0;
      #1;
      chk("frozen data_out", dsave, {parity_out, data_out});
    end
  endtask : hold
  task automatic burst(input logic wr, input logic [9:0] a, input int f);
    for (int i = 0; i < 4; i++) begin
      qv = (i == f);
      step(i != 0, wr, 1'b1, {a[9:2], burst_order ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i)});
      if (i == f) hold();
    end
  endtask : burst
  task automatic t_single();
    step(1'b0, 1'b1, 1'b1, 10'h010);
    step(1'b0, 1'b1, 1'b1, 10'h011);
    lanes = 4'ha;
    step(1'b0, 1'b1, 1'b1, 10'h011);
    lanes = 4'h0;
    step(1'b0, 1'b0, 1'b1, 10'h010);
    step(1'b0, 1'b0, 1'b1, 10'h010);
    step(1'b0, 1'b0, 1'b1, 10'h011);
    $display("test single done");
  endtask : t_single
  task automatic t_linear();
    burst(1'b1, 10'h102, 4);
    burst(1'b0, 10'h103, 2);
    burst(1'b0, 10'h100, 4);
    step(1'b0, 1'b0, 1'b0, 10'h000);
    step(1'b0, 1'b0, 1'b0, 10'h000);
    $display("test linear done");
  endtask : t_linear
  // Eleven reads went in while stalled: eight come out, in order
  task automatic t_fifo();
    for (int c = 0; c < 80 && fq.size() > 0; c++) begin
      @(posedge mclk);
      if (rd_valid === 1'b1 && rd_ready) chk("rd_data", fq.pop_front(), rd_data);
      rd_ready <= !rd_ready;
    end
    if (fq.size() != 0) begin
      n_errors++;
      complete_run();
    end
    repeat (4) @(posedge mclk);
    #1;
    chk("rd_valid", 36'h0_0000_0000, 36'(rd_valid));
    $display("test fifo done");
  endtask : t_fifo
  task automatic t_inter();
    rst(1'b1);
    fq_on = 1'b0;
    burst(1'b1, 10'h201, 4);
    burst(1'b0, 10'h200, 4);
    step(1'b0, 1'b0, 1'b0, 10'h000);
    step(1'b0, 1'b0, 1'b1, 10'h202);
    step(1'b0, 1'b0, 1'b1, 10'h203);
    step(1'b0, 1'b0, 1'b0, 10'h000);
    step(1'b0, 1'b0, 1'b0, 10'h000);
    $display("test interleaved done");
  endtask : t_inter
  initial begin
    rst(1'b0);
    fq_on = 1'b1;
    t_single();
    t_linear();
    t_fifo();
    t_inter();
    complete_run();
  end
endmodule : testbench
`default_nettype wire
